/* psm_top.sv */
// Pin function selection for the three downstream hot-plug ports and the GPIO banks.
// Assumes pins and straps are synchronous to sys_clk_i; the pad ring resolves oe_n into the wire.
module psm_top
  import psm_pkg::*;
#(
  parameter int unsigned CLK_HOLD_CYCLES = psm_pkg::CLK_HOLD_CYC,
  parameter int unsigned PWR_HOLD_CYCLES = psm_pkg::PWR_HOLD_CYC
) (
  input  wire logic                               sys_clk_i,                  // 200 MHz clock
  input  wire logic                               srst_i,                     // Sync reset, active high
  input  wire logic                               global_reset_n_i,           // Global power-on reset pin
  input  wire logic                               link_reset_n_i,             // Link reset pin
  input  wire psm_pkg::psm_axil_req_type          axil_req_i,                 // AXI4-Lite master side
  output psm_pkg::psm_axil_rsp_type               axil_rsp_o,                 // AXI4-Lite slave answers
  input  wire logic                               port1_hotplug_strap_i,      // Port 1 strap pin
  input  wire logic                               port2_hotplug_strap_i,      // Port 2 strap pin
  input  wire logic                               port3_hotplug_strap_i,      // Port 3 strap pin
  input  wire logic [psm_pkg::GPIO_COUNT-1:0]     gpio_pin_i,                 // Pad levels
  output logic      [psm_pkg::GPIO_COUNT-1:0]     gpio_pin_o,                 // Pad drive levels
  output logic      [psm_pkg::GPIO_COUNT-1:0]     gpio_pin_oe_n_o,            // Pad enables, low drives
  input  wire logic [psm_pkg::PORT_COUNT-1:0]     slot_power_enable_i,        // From hot-plug control
  output logic      [psm_pkg::PORT_COUNT-1:0]     slot_presence_o,            // To hot-plug control
  output logic      [psm_pkg::PORT_COUNT-1:0]     slot_power_ok_o,            // To hot-plug control
  input  wire logic                               link_in_l1_i,               // Link sits in L1
  input  wire logic                               clock_needed_i,             // Link wants to leave L1
  output logic                                    upstream_clock_request_n_o  // Clock request, active low
);
  import psm_pkg::*;

  // Reset and strap capture
  logic                   dev_rst;
  logic                   in_reset_q;
  logic                   strap_capture;
  logic [PORT_COUNT-1:0]  straps_in;
  logic [PORT_COUNT-1:0]  strap;

  // Link reset hold monitor
  logic                   link_rst_prev;
  logic [HOLD_CNT_W-1:0]  hold_cnt;
  logic                   clk_short;
  logic                   pwr_short;

  // Register file
  logic [GPIO_COUNT-1:0]  gpio_dir;
  logic [GPIO_COUNT-1:0]  gpio_data;
  logic [GPIO_COUNT-1:0]  gpio_in_q;
  logic                   clkreq_en;

  // Pin multiplexer
  logic [GPIO_COUNT-1:0]  hp_claim;
  logic [GPIO_COUNT-1:0]  hp_drive;
  logic [GPIO_COUNT-1:0]  hp_level;
  logic [GPIO_COUNT-1:0]  next_pin_out;
  logic [GPIO_COUNT-1:0]  next_pin_oe_n;
  logic [PORT_COUNT-1:0]  next_presence;
  logic [PORT_COUNT-1:0]  next_power_ok;
  logic                   next_clkreq_n;

  // Bus decode
  logic                   aw_go;
  logic                   ar_go;
  logic                   wr_en;
  logic                   wr_a;
  logic                   wr_b;
  logic                   wr_c;
  logic                   wr_data;
  logic                   wr_clkreq;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [31:0]            rd_word;
  logic [31:0]            stat_word;
  logic [31:0]            wr_a_val;
  logic [31:0]            wr_b_val;
  logic [31:0]            wr_c_val;
  logic [31:0]            wr_data_val;
  logic [31:0]            wr_clkreq_val;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Either reset pin resets pins, registers and straps and starts a new strap capture; only the global pin clears the hold monitor
  assign dev_rst       = srst_i | ~global_reset_n_i | ~link_reset_n_i;
  assign straps_in     = {port3_hotplug_strap_i, port2_hotplug_strap_i, port1_hotplug_strap_i};
  assign strap_capture = in_reset_q & ~dev_rst;

  always_ff @(posedge sys_clk_i) begin
    in_reset_q <= dev_rst;
  end

  // Straps caught on the first clock after release and frozen until the next reset
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      strap <= '0;
    end else if (strap_capture) begin
      strap <= straps_in;
    end
  end

  // Hold monitor survives link reset so software can see a short pulse afterwards
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !global_reset_n_i) begin
      // Idle level of the pin, so leaving a global reset is no false release
      link_rst_prev <= 1'b1;
      hold_cnt      <= '0;
      clk_short     <= 1'b0;
      pwr_short     <= 1'b0;
    end else begin
      link_rst_prev <= link_reset_n_i;
      if (!link_reset_n_i) begin
        if (hold_cnt != '1) begin
          hold_cnt <= hold_cnt + 1'b1;
        end
      end else if (!link_rst_prev) begin
        clk_short <= 32'(hold_cnt) < CLK_HOLD_CYCLES;
        pwr_short <= 32'(hold_cnt) < PWR_HOLD_CYCLES;
        hold_cnt  <= '0;
      end
    end
  end

  // Per-pin function selection
  for (genvar i = 0; i < GPIO_COUNT; i++) begin : g_pin
    localparam int PORT = i / PORT_PIN_STRIDE;
    localparam int ROLE = i % PORT_PIN_STRIDE;
    if (PORT < PORT_COUNT && ROLE < HP_PIN_COUNT) begin : g_shared
      assign hp_claim[i] = strap[PORT];
      assign hp_drive[i] = (ROLE == ROLE_POWER_EN);
      assign hp_level[i] = (ROLE == ROLE_POWER_EN) ? slot_power_enable_i[PORT] : 1'b0;
    end else begin : g_plain
      assign hp_claim[i] = 1'b0;
      assign hp_drive[i] = 1'b0;
      assign hp_level[i] = 1'b0;
    end
    // Claimed pins ignore direction and data registers entirely
    assign next_pin_oe_n[i] = hp_claim[i] ? ~hp_drive[i] : ~gpio_dir[i];
    assign next_pin_out[i]  = hp_claim[i] ? hp_level[i] : gpio_data[i];
  end

  for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
    assign next_presence[p] = strap[p] & gpio_pin_i[p*PORT_PIN_STRIDE + ROLE_PRESENCE];
    assign next_power_ok[p] = strap[p] & gpio_pin_i[p*PORT_PIN_STRIDE + ROLE_POWER_OK];
  end

  assign next_clkreq_n = ~(clkreq_en & link_in_l1_i & clock_needed_i);

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      gpio_pin_o                 <= '0;
      gpio_pin_oe_n_o            <= '1;
      slot_presence_o            <= '0;
      slot_power_ok_o            <= '0;
      upstream_clock_request_n_o <= 1'b1;
      gpio_in_q                  <= '0;
    end else begin
      gpio_pin_o                 <= next_pin_out;
      gpio_pin_oe_n_o            <= next_pin_oe_n;
      slot_presence_o            <= next_presence;
      slot_power_ok_o            <= next_power_ok;
      upstream_clock_request_n_o <= next_clkreq_n;
      gpio_in_q                  <= gpio_pin_i;
    end
  end

  // AXI4-Lite slave: address and data are taken together once both are offered
  assign aw_go     = axil_req_i.awvalid & axil_req_i.wvalid & ~axil_rsp_o.awready & ~axil_rsp_o.bvalid;
  assign ar_go     = axil_req_i.arvalid & ~axil_rsp_o.arready & ~axil_rsp_o.rvalid;
  assign wr_en     = axil_rsp_o.awready;
  assign wr_a      = wr_en && axil_req_i.awaddr == OFS_GRPA_CTRL;
  assign wr_b      = wr_en && axil_req_i.awaddr == OFS_GRPB_CTRL;
  assign wr_c      = wr_en && axil_req_i.awaddr == OFS_GRPC_CTRL;
  assign wr_data   = wr_en && axil_req_i.awaddr == OFS_GPIO_DATA;
  assign wr_clkreq = wr_en && axil_req_i.awaddr == OFS_CLKREQ_CTRL;
  // Read-only registers accept writes silently
  assign wr_hit    = wr_a || wr_b || wr_c || wr_data || wr_clkreq ||
                     axil_req_i.awaddr == OFS_GPIO_IN || axil_req_i.awaddr == OFS_STRAP_STAT;

  assign wr_a_val      = merge_strb(32'(gpio_dir[GRPA_W-1:0]), axil_req_i.wdata, axil_req_i.wstrb);
  assign wr_b_val      = merge_strb(32'(gpio_dir[GRPB_LSB +: GRPB_W]), axil_req_i.wdata, axil_req_i.wstrb);
  assign wr_c_val      = merge_strb(32'(gpio_dir[GRPC_LSB +: GRPC_W]), axil_req_i.wdata, axil_req_i.wstrb);
  assign wr_data_val   = merge_strb(32'(gpio_data), axil_req_i.wdata, axil_req_i.wstrb);
  assign wr_clkreq_val = merge_strb(32'(clkreq_en), axil_req_i.wdata, axil_req_i.wstrb);

  assign stat_word = 32'(strap) | (32'(clk_short) << STAT_CLK_SHORT_BIT) | (32'(pwr_short) << STAT_PWR_SHORT_BIT);

  assign rd_word = (axil_req_i.araddr == OFS_GRPA_CTRL)   ? 32'(gpio_dir[GRPA_W-1:0]) :
                   (axil_req_i.araddr == OFS_GRPB_CTRL)   ? 32'(gpio_dir[GRPB_LSB +: GRPB_W]) :
                   (axil_req_i.araddr == OFS_GRPC_CTRL)   ? 32'(gpio_dir[GRPC_LSB +: GRPC_W]) :
                   (axil_req_i.araddr == OFS_GPIO_DATA)   ? 32'(gpio_data) :
                   (axil_req_i.araddr == OFS_GPIO_IN)     ? 32'(gpio_in_q) :
                   (axil_req_i.araddr == OFS_STRAP_STAT)  ? stat_word :
                   (axil_req_i.araddr == OFS_CLKREQ_CTRL) ? 32'(clkreq_en) : 32'h0;
  assign rd_hit  = axil_req_i.araddr == OFS_GRPA_CTRL || axil_req_i.araddr == OFS_GRPB_CTRL ||
                   axil_req_i.araddr == OFS_GRPC_CTRL || axil_req_i.araddr == OFS_GPIO_DATA ||
                   axil_req_i.araddr == OFS_GPIO_IN || axil_req_i.araddr == OFS_STRAP_STAT ||
                   axil_req_i.araddr == OFS_CLKREQ_CTRL;

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      gpio_dir  <= RST_GPIO_DIR;
      gpio_data <= RST_GPIO_DATA;
      clkreq_en <= RST_CLKREQ_EN;
    end else begin
      if (wr_a) begin
        gpio_dir[GRPA_W-1:0] <= wr_a_val[GRPA_W-1:0];
      end
      if (wr_b) begin
        gpio_dir[GRPB_LSB +: GRPB_W] <= wr_b_val[GRPB_W-1:0];
      end
      if (wr_c) begin
        gpio_dir[GRPC_LSB +: GRPC_W] <= wr_c_val[GRPC_W-1:0];
      end
      if (wr_data) begin
        gpio_data <= wr_data_val[GPIO_COUNT-1:0];
      end
      if (wr_clkreq) begin
        clkreq_en <= wr_clkreq_val[0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      axil_rsp_o <= '0;
    end else begin
      axil_rsp_o.awready <= aw_go;
      axil_rsp_o.wready  <= aw_go;
      axil_rsp_o.arready <= ar_go;
      if (wr_en) begin
        axil_rsp_o.bvalid <= 1'b1;
        axil_rsp_o.bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req_i.bready) begin
        axil_rsp_o.bvalid <= 1'b0;
      end
      if (axil_rsp_o.arready) begin
        axil_rsp_o.rvalid <= 1'b1;
        axil_rsp_o.rdata  <= rd_word;
        axil_rsp_o.rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req_i.rready) begin
        axil_rsp_o.rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (dev_rst);

  sequence reset_release_s;
    dev_rst ##1 !dev_rst;
  endsequence

  sequence clkreq_cause_s;
    clkreq_en && link_in_l1_i && clock_needed_i;
  endsequence

  strap_capture_a: assert property (disable iff (srst_i)
    reset_release_s |=> dev_rst || strap == $past(straps_in))
    else $error("strap not captured at reset release");

  strap_hold_a: assert property (!strap_capture |=> $stable(strap))
    else $error("strap changed outside reset release");

  port1_pins_a: assert property (strap[0] ##1 strap[0] |->
    gpio_pin_oe_n_o[2:0] == 3'b101 && gpio_pin_o[1] == $past(slot_power_enable_i[0])
    && slot_presence_o[0] == $past(gpio_pin_i[0]) && slot_power_ok_o[0] == $past(gpio_pin_i[2]))
    else $error("port 1 hot-plug pins wrong");

  port2_pins_a: assert property (strap[1] ##1 strap[1] |->
    gpio_pin_oe_n_o[6:4] == 3'b101 && gpio_pin_o[5] == $past(slot_power_enable_i[1])
    && slot_presence_o[1] == $past(gpio_pin_i[4])
    && slot_power_ok_o[1] == $past(gpio_pin_i[6]))
    else $error("port 2 hot-plug pins wrong");

  port3_pins_a: assert property (strap[2] ##1 strap[2] |->
    gpio_pin_oe_n_o[10:8] == 3'b101 && gpio_pin_o[9] == $past(slot_power_enable_i[2])
    && slot_power_ok_o[2] == $past(gpio_pin_i[10])
    && slot_presence_o[2] == $past(gpio_pin_i[8]))
    else $error("port 3 hot-plug pins wrong");

  unclaimed_gpio_a: assert property (!strap[0] ##1 !strap[0] |->
    gpio_pin_oe_n_o[1] == !$past(gpio_dir[1]) && gpio_pin_o[1] == $past(gpio_data[1])
    && !slot_presence_o[0])
    else $error("unclaimed port 1 pin not under GPIO control");

  group_a_fixed_a: assert property (1'b1 |=>
    gpio_pin_oe_n_o[3] == !$past(gpio_dir[3]) && gpio_pin_oe_n_o[7] == !$past(gpio_dir[7]))
    else $error("group A fixed pins not under control");

  group_b_fixed_a: assert property (1'b1 |=>
    gpio_pin_oe_n_o[15:11] == ~$past(gpio_dir[15:11]) && gpio_pin_o[15:11] == $past(gpio_data[15:11]))
    else $error("group B fixed pins not under control");

  group_c_pins_a: assert property (wr_c ##1 1'b1 |=>
    gpio_pin_oe_n_o[18:16] == ~$past(axil_req_i.wdata[2:0], 2) || !$past(axil_req_i.wstrb[0], 2))
    else $error("group C write did not reach pins");

  hotplug_isolation_a: assert property (strap[2] ##1 strap[2] |-> gpio_pin_oe_n_o[8] && gpio_pin_oe_n_o[10])
    else $error("hot-plug input pin driven by GPIO control");

  clock_request_a: assert property (clkreq_cause_s |=> !upstream_clock_request_n_o)
    else $error("clock request not raised");

  clock_idle_a: assert property (!(clkreq_en && link_in_l1_i && clock_needed_i) |=> upstream_clock_request_n_o)
    else $error("clock request raised without cause");

  global_reset_a: assert property (disable iff (srst_i) !global_reset_n_i |=>
    strap == '0 && gpio_pin_oe_n_o == '1 && upstream_clock_request_n_o && gpio_dir == RST_GPIO_DIR)
    else $error("global reset did not clear the block");

  hold_flags_a: assert property (disable iff (srst_i)
    !global_reset_n_i ##1 (global_reset_n_i && link_reset_n_i) |=> !clk_short && !pwr_short)
    else $error("hold flag set without a link reset");

  unclaimed_port3_a: assert property (!strap[2] ##1 !strap[2] |->
    gpio_pin_oe_n_o[9] == !$past(gpio_dir[9]) && gpio_pin_o[9] == $past(gpio_data[9])
    && !slot_power_ok_o[2])
    else $error("unclaimed port 3 pin not under GPIO control");
endmodule

/* psm_pkg.sv */
// Constants, register map and bus carriers for the port strap pin multiplexer.
// Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
package psm_pkg;
  localparam int GPIO_COUNT       = 19;
  localparam int PORT_COUNT       = 3;
  localparam int ADDR_W           = 8;
  // Pin layout of the shared hot-plug pins: port p owns pins 4p .. 4p+2
  localparam int PORT_PIN_STRIDE  = 4;
  localparam int HP_PIN_COUNT     = 3;
  localparam int ROLE_PRESENCE    = 0;
  localparam int ROLE_POWER_EN    = 1;
  localparam int ROLE_POWER_OK    = 2;
  // Control group widths and their first pin
  localparam int GRPA_W           = 8;
  localparam int GRPB_W           = 8;
  localparam int GRPC_W           = 3;
  localparam int GRPB_LSB         = 8;
  localparam int GRPC_LSB         = 16;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_GRPA_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GRPB_CTRL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GRPC_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GPIO_DATA   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_GPIO_IN     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STRAP_STAT  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CLKREQ_CTRL = 8'h18;
  // Status fields
  localparam int STAT_CLK_SHORT_BIT = 8;
  localparam int STAT_PWR_SHORT_BIT = 9;
  // Reset values
  localparam logic [GPIO_COUNT-1:0] RST_GPIO_DIR  = 19'h0;
  localparam logic [GPIO_COUNT-1:0] RST_GPIO_DATA = 19'h0;
  localparam logic                  RST_CLKREQ_EN = 1'b0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Link reset hold times seen at the pin
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CLK_HOLD_US   = 100;
  localparam int unsigned PWR_HOLD_MS   = 100;
  localparam int unsigned CLK_HOLD_CYC  = (CLK_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PWR_HOLD_CYC  =
    int'((longint'(PWR_HOLD_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int HOLD_CNT_W = 25;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } psm_axil_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } psm_axil_rsp_type;
endpackage

/* psm_slot_model.sv */
// Slot side of the hot-plug pins: presence switch, power switch with its good signal, loose board pins.
// Assumes pins 4p..4p+2 of the pad bus belong to slot p and that the board has no pulls on them.
module psm_slot_model
  import psm_pkg::*;
#(
  parameter int OK_DELAY = 3
) (
  input  wire logic                         sys_clk_i,       // Board clock
  input  wire logic [psm_pkg::GPIO_COUNT-1:0] pin_drive_i,   // Device drive levels
  input  wire logic [psm_pkg::GPIO_COUNT-1:0] pin_oe_n_i,    // Device enables, low drives
  input  wire logic [psm_pkg::PORT_COUNT-1:0] slot_slot_presence_i,// Card seated per slot
  output logic      [psm_pkg::GPIO_COUNT-1:0] pad_o          // Resolved pad levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [GPIO_COUNT-1:0] board_level = '0;
  logic [GPIO_COUNT-1:0] ext;
  logic [OK_DELAY-1:0]   ok_pipe [PORT_COUNT] = '{default: '0};
  always @(posedge sys_clk_i) begin
    // Undriven pins wander so a stale level never passes for a read
    board_level <= ~board_level;
    for (int p = 0; p < PORT_COUNT; p++) begin
      ok_pipe[p] <= {ok_pipe[p][OK_DELAY-2:0],
                     ~pin_oe_n_i[PORT_PIN_STRIDE*p+ROLE_POWER_EN] & pin_drive_i[PORT_PIN_STRIDE*p+ROLE_POWER_EN]};
    end
  end
  always_comb begin
    ext = board_level;
    for (int p = 0; p < PORT_COUNT; p++) begin
      ext[PORT_PIN_STRIDE*p+ROLE_PRESENCE] = slot_slot_presence_i[p];
      ext[PORT_PIN_STRIDE*p+ROLE_POWER_OK] = ok_pipe[p][OK_DELAY-1];
    end
    pad_o = (pin_drive_i & ~pin_oe_n_i) | (ext & pin_oe_n_i);
  end
endmodule

/* port_strap_pin_mux_test.sv */
// Testbench for the strap pin multiplexer: register access, pin map, resets.
// Assumes the slot model resolves the pads and the hold counts are shortened to 20 and 40.
module port_strap_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import psm_pkg::*;
  logic sys_clk, srst, global_reset_n_n, lrst_n, l1, need, crq_n;
  logic [2:0] straps, pwr_en, slot_presence, presence, pwr_ok;
  logic [18:0] pad, pin_o, oe_n;
  psm_axil_req_type req;
  psm_axil_rsp_type rsp;
  int failures = 0;
  int comparisons = 0;
  psm_top #(.CLK_HOLD_CYCLES(20), .PWR_HOLD_CYCLES(40)) psm_top_i (
    .sys_clk_i(sys_clk), .srst_i(srst), .global_reset_n_i(global_reset_n_n), .link_reset_n_i(lrst_n),
    .axil_req_i(req), .axil_rsp_o(rsp), .port1_hotplug_strap_i(straps[0]), .port2_hotplug_strap_i(straps[1]),
    .port3_hotplug_strap_i(straps[2]), .gpio_pin_i(pad), .gpio_pin_o(pin_o), .gpio_pin_oe_n_o(oe_n),
    .slot_power_enable_i(pwr_en), .slot_presence_o(presence), .slot_power_ok_o(pwr_ok),
    .link_in_l1_i(l1), .clock_needed_i(need), .upstream_clock_request_n_o(crq_n));
  psm_slot_model psm_slot_model_i (.sys_clk_i(sys_clk), .pin_drive_i(pin_o), .pin_oe_n_i(oe_n),
    .slot_slot_presence_i(slot_presence), .pad_o(pad));
  always #2.5 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Called just after a rising edge; valids held until ready, bready/rready until the answer
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] resp);
    int n;
    n = 0;
    req <= '{awaddr: a, awvalid: wr, wdata: d, wstrb: 4'hf, wvalid: wr, bready: wr, araddr: a, arvalid: !wr,
             rready: !wr};
    do begin
      @(posedge sys_clk);
      n++;
    end while ((wr ? rsp.awready : rsp.arready) !== 1'b1 && n < 50);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    req.arvalid <= 1'b0;
    while ((wr ? rsp.bvalid : rsp.rvalid) !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    rd = rsp.rdata;
    resp = wr ? rsp.bresp : rsp.rresp;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
    if (n >= 50) begin
      failures++;
      $display("mismatch bus answer expected answer seen timeout");
      finish_test();
    end
    @(posedge sys_clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0] r;
    axi(1'b1, a, d, x, r);
    chk("bresp", 32'(r), 32'(er));
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0] r;
    axi(1'b0, a, 32'h0, x, r);
    chk("rdata", x, ed);
    chk("rresp", 32'(r), 32'(er));
  endtask
  task automatic settle(input int n, input string done);
    repeat (n) @(posedge sys_clk);
    if (done != "") $display("test %s done", done);
  endtask
  initial begin
    sys_clk = 1'b0;
    srst = 1'b1;
    global_reset_n_n = 1'b1;
    lrst_n = 1'b0;
    req = '0;
    straps = 3'b101;
    {pwr_en, slot_presence, l1, need} = '0;
    settle(6, "");
    srst <= 1'b0;
    settle(44, "");
    lrst_n <= 1'b1;
    settle(4, "");
    reg_rd(OFS_STRAP_STAT, 32'h5, RESP_OKAY);
    chk("pad enables", 32'(oe_n), 32'h7fdfd);
    reg_wr(OFS_GRPA_CTRL, 32'hff, RESP_OKAY);
    reg_wr(OFS_GRPB_CTRL, 32'hff, RESP_OKAY);
    reg_wr(OFS_GRPC_CTRL, 32'h7, RESP_OKAY);
    reg_wr(OFS_GPIO_DATA, 32'h7ffff, RESP_OKAY);
    settle(2, "");
    chk("pad enables", 32'(oe_n), 32'h00505);
    chk("driven levels", 32'(pin_o | oe_n), 32'h7fdfd);
    settle(0, "pin map");
    pwr_en <= 3'b101;
    slot_presence <= 3'b001;
    settle(8, "");
    chk("driven levels", 32'(pin_o | oe_n), 32'h7ffff);
    chk("presence", 32'(presence), 32'h1);
    chk("power ok", 32'(pwr_ok), 32'h5);
    reg_rd(OFS_GPIO_IN, 32'h7feff, RESP_OKAY);
    reg_rd(OFS_GPIO_DATA, 32'h7ffff, RESP_OKAY);
    straps <= 3'b010;
    settle(3, "");
    reg_rd(OFS_STRAP_STAT, 32'h5, RESP_OKAY);
    chk("pad enables", 32'(oe_n), 32'h00505);
    settle(0, "slot pins");
    reg_rd(8'h1c, 32'h0, RESP_SLVERR);
    reg_wr(8'h1c, 32'hffffffff, RESP_SLVERR);
    reg_wr(OFS_STRAP_STAT, 32'hffffffff, RESP_OKAY);
    reg_rd(OFS_STRAP_STAT, 32'h5, RESP_OKAY);
    reg_rd(OFS_GRPC_CTRL, 32'h7, RESP_OKAY);
    settle(0, "bus");
    reg_wr(OFS_CLKREQ_CTRL, 32'h1, RESP_OKAY);
    l1 <= 1'b1;
    need <= 1'b1;
    settle(3, "");
    chk("clock request", 32'(crq_n), 32'h0);
    need <= 1'b0;
    settle(3, "");
    chk("clock request", 32'(crq_n), 32'h1);
    reg_wr(OFS_CLKREQ_CTRL, 32'h0, RESP_OKAY);
    need <= 1'b1;
    settle(3, "");
    chk("clock request", 32'(crq_n), 32'h1);
    settle(0, "clock request");
    global_reset_n_n <= 1'b0;
    settle(3, "");
    chk("pad enables", 32'(oe_n), 32'h7ffff);
    global_reset_n_n <= 1'b1;
    settle(4, "");
    reg_rd(OFS_STRAP_STAT, 32'h2, RESP_OKAY);
    reg_rd(OFS_GRPA_CTRL, 32'h0, RESP_OKAY);
    chk("pad enables", 32'(oe_n), 32'h7ffdf);
    settle(0, "global reset");
    lrst_n <= 1'b0;
    settle(30, "");
    lrst_n <= 1'b1;
    settle(4, "");
    reg_rd(OFS_STRAP_STAT, 32'h202, RESP_OKAY);
    settle(0, "link reset hold");
    finish_test();
  end
endmodule
